// file: logic/fgpwm_pkg.sv
// Shared constants and types of the four-group pulse-width generator
package fgpwm_pkg;

   // Structure of the generator
   localparam int GRP_N = 4; // Output groups
   localparam int CH_N = 4; // Outputs (and duty settings) per group
   localparam int OUT_N = GRP_N * CH_N; // Sixteen outputs in all
   localparam int CNT_W = 16; // Counter, period and duty width

   // Reset values of the working copies and counter, and the counter step
   localparam logic [CNT_W-1:0] PER_RST = 16'h0000; // Active period
   localparam logic [CNT_W-1:0] DUTY_RST = 16'h0000; // Active duty
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000; // Counter start value
   localparam logic [CNT_W-1:0] CNT_STEP = 16'h0001; // Counter step

   // Counter phase; Gray coded along idle, up, down
   typedef enum logic [1:0] {
      PH_IDLE = 2'h0,
      PH_UP = 2'h1,
      PH_DOWN = 2'h3
   } fgpwm_phase_t;

endpackage

// file: logic/fgpwm_cmp.sv
`timescale 1ns/1ps

// One compare channel: turns a count into an output level
module fgpwm_cmp (
   input wire logic [15:0] cnt,
   input wire logic [15:0] duty,
   input wire logic [15:0] period,
   input wire logic center_mode,
   output logic level_hi
);

   logic [16:0] sum; // Count plus duty, one bit wider to avoid wrap

   // Centered pulse is high for the top duty counts of the up/down ramp
   always_comb
   begin
      sum = {1'b0, cnt} + {1'b0, duty};
      if (center_mode)
      begin
         level_hi = (sum >= {1'b0, period});
      end
      else
      begin
         // Edge mode: high from the period start for duty counts
         level_hi = (cnt < duty);
      end
   end

endmodule // fgpwm_cmp

// file: logic/fgpwm_top.sv
`timescale 1ns/1ps

// What this block does
// - Four independent groups, sixteen outputs total
// - Each group forms two pairs, shared setting
// - Center-aligned up/down or edge-aligned waveform
// - Paired group: pair outputs are complements
// - Non-paired group: four independent outputs, per group
// - Center mode offers single or double update
// - Single update: duties load once per period
// - Double update: duties also load at midpoint
module fgpwm_top (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [3:0] grp_enable,
   input wire logic [3:0] grp_edge_mode,
   input wire logic [3:0] grp_dbl_update,
   input wire logic [3:0] grp_paired,
   input wire logic [63:0] period_in,
   input wire logic [255:0] duty_in,
   output logic [15:0] pwm_out,
   output logic [3:0] period_start,
   output logic [3:0] mid_point
);

   localparam int GN = fgpwm_pkg::GRP_N; // Group count
   localparam int CN = fgpwm_pkg::CH_N; // Channels per group
   localparam int W = fgpwm_pkg::CNT_W; // Counter width

   // Per-group counter state
   fgpwm_pkg::fgpwm_phase_t phase_q [GN];
   fgpwm_pkg::fgpwm_phase_t phase_d [GN];
   logic [W-1:0] cnt_q [GN];
   logic [W-1:0] cnt_d [GN];
   // Working copies of the settings, changed only at update points
   logic [W-1:0] per_q [GN];
   logic [W-1:0] per_d [GN];
   logic [W-1:0] duty_q [GN][CN];
   logic [W-1:0] duty_d [GN][CN];
   logic [GN-1:0] edge_q, edge_d; // Edge-aligned mode per group
   logic [GN-1:0] paired_q, paired_d; // Complementary mode per group
   logic [GN-1:0] dbl_q, dbl_d; // Double update per group
   // Event pulses and registered outputs
   logic [GN-1:0] start_q, start_d;
   logic [GN-1:0] mid_q, mid_d;
   logic [15:0] pwm_q, pwm_d;
   logic [15:0] cmp_hi; // Raw compare levels, one per channel

   // Slice of the packed duty input for one group and channel
   function automatic logic [15:0] duty_of(input logic [255:0] v, input int g, input int c);
      return v[(g * CN + c) * W +: W];
   endfunction

   // Last count of the ramp; a zero period is treated as one count
   function automatic logic [15:0] top_of(input logic [15:0] p);
      return (p == 16'h0000) ? 16'h0000 : p - fgpwm_pkg::CNT_STEP;
   endfunction

   // Sixteen compare channels, four per group
   genvar gi, ci;
   generate
      for (gi = 0; gi < GN; gi++)
      begin : g_grp
         for (ci = 0; ci < CN; ci++)
         begin : g_ch
            fgpwm_cmp u_cmp (
               .cnt(cnt_q[gi]),
               .duty(duty_q[gi][ci]),
               .period(per_q[gi]),
               .center_mode(~edge_q[gi]),
               .level_hi(cmp_hi[gi * CN + ci])
            );
         end
      end
   endgenerate

   // Next state of counters, working settings and outputs
   always_comb
   begin
      for (int g = 0; g < GN; g++)
      begin
         phase_d[g] = phase_q[g];
         cnt_d[g] = cnt_q[g];
         per_d[g] = per_q[g];
         for (int c = 0; c < CN; c++)
         begin
            duty_d[g][c] = duty_q[g][c];
         end
         edge_d[g] = edge_q[g];
         paired_d[g] = paired_q[g];
         dbl_d[g] = dbl_q[g];
         start_d[g] = 1'b0;
         mid_d[g] = 1'b0;
         if (!grp_enable[g])
         begin
            // Disabled group parks with outputs low
            phase_d[g] = fgpwm_pkg::PH_IDLE;
            cnt_d[g] = fgpwm_pkg::CNT_RST;
         end
         else
         begin
            unique case (phase_q[g])
               fgpwm_pkg::PH_IDLE:
               begin
                  // First period begins with a fresh load
                  phase_d[g] = fgpwm_pkg::PH_UP;
                  cnt_d[g] = fgpwm_pkg::CNT_RST;
                  start_d[g] = 1'b1;
               end
               fgpwm_pkg::PH_UP:
               begin
                  if (cnt_q[g] >= top_of(per_q[g]))
                  begin
                     if (edge_q[g])
                     begin
                        // Edge mode wraps to a new period
                        cnt_d[g] = fgpwm_pkg::CNT_RST;
                        start_d[g] = 1'b1;
                     end
                     else
                     begin
                        // Top count is held twice so the ramp stays symmetric
                        phase_d[g] = fgpwm_pkg::PH_DOWN;
                        mid_d[g] = 1'b1;
                     end
                  end
                  else
                  begin
                     cnt_d[g] = cnt_q[g] + fgpwm_pkg::CNT_STEP;
                  end
               end
               fgpwm_pkg::PH_DOWN:
               begin
                  if (cnt_q[g] == fgpwm_pkg::CNT_RST)
                  begin
                     // Bottom count also held twice, then a new period
                     phase_d[g] = fgpwm_pkg::PH_UP;
                     start_d[g] = 1'b1;
                  end
                  else
                  begin
                     cnt_d[g] = cnt_q[g] - fgpwm_pkg::CNT_STEP;
                  end
               end
               default:
               begin
                  // Illegal code recovers through idle
                  phase_d[g] = fgpwm_pkg::PH_IDLE;
                  cnt_d[g] = fgpwm_pkg::CNT_RST;
               end
            endcase
         end
         // Period start: every setting taken from the shadow inputs
         if (start_d[g])
         begin
            per_d[g] = period_in[g * W +: W];
            edge_d[g] = grp_edge_mode[g];
            paired_d[g] = grp_paired[g];
            dbl_d[g] = grp_dbl_update[g];
            for (int c = 0; c < CN; c++)
            begin
               duty_d[g][c] = duty_of(duty_in, g, c);
            end
         end
         // Midpoint: duties only, and only with double update
         else if (mid_d[g] && dbl_q[g])
         begin
            for (int c = 0; c < CN; c++)
            begin
               duty_d[g][c] = duty_of(duty_in, g, c);
            end
         end
         // Output steering; pairs share the even channel when paired
         for (int p = 0; p < CN / 2; p++)
         begin
            pwm_d[g * CN + 2 * p] = (phase_q[g] != fgpwm_pkg::PH_IDLE)
               && cmp_hi[g * CN + 2 * p];
            if (paired_q[g])
            begin
               pwm_d[g * CN + 2 * p + 1] = (phase_q[g] != fgpwm_pkg::PH_IDLE)
                  && !cmp_hi[g * CN + 2 * p];
            end
            else
            begin
               pwm_d[g * CN + 2 * p + 1] = (phase_q[g] != fgpwm_pkg::PH_IDLE)
                  && cmp_hi[g * CN + 2 * p + 1];
            end
         end
      end
   end

   // Registers only; idle and low after reset
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         for (int g = 0; g < GN; g++)
         begin
            phase_q[g] <= fgpwm_pkg::PH_IDLE;
            cnt_q[g] <= fgpwm_pkg::CNT_RST;
            per_q[g] <= fgpwm_pkg::PER_RST;
            for (int c = 0; c < CN; c++)
            begin
               duty_q[g][c] <= fgpwm_pkg::DUTY_RST;
            end
         end
         edge_q <= 4'h0;
         paired_q <= 4'h0;
         dbl_q <= 4'h0;
         start_q <= 4'h0;
         mid_q <= 4'h0;
         pwm_q <= 16'h0000;
      end
      else
      begin
         phase_q <= phase_d;
         cnt_q <= cnt_d;
         per_q <= per_d;
         duty_q <= duty_d;
         edge_q <= edge_d;
         paired_q <= paired_d;
         dbl_q <= dbl_d;
         start_q <= start_d;
         mid_q <= mid_d;
         pwm_q <= pwm_d;
      end
   end

   // Outputs straight from flip-flops
   assign pwm_out = pwm_q;
   assign period_start = start_q;
   assign mid_point = mid_q;

   // Per-group checks
   generate
      for (gi = 0; gi < GN; gi++)
      begin : g_chk
         // Counter stays inside the programmed period
         cnt_bound_a: assert property (@(posedge sys_clk) disable iff (reset)
            (phase_q[gi] != fgpwm_pkg::PH_IDLE && per_q[gi] != 16'h0000)
               |-> cnt_q[gi] <= per_q[gi] - 16'h0001)
            else $error("counter beyond period");
         // Center ramp turns at the top and holds the count
         center_turn_a: assert property (@(posedge sys_clk) disable iff (reset)
            (grp_enable[gi] && phase_q[gi] == fgpwm_pkg::PH_UP && !edge_q[gi]
               && cnt_q[gi] >= top_of(per_q[gi]))
               |=> (phase_q[gi] == fgpwm_pkg::PH_DOWN && $stable(cnt_q[gi]) && mid_q[gi]))
            else $error("center ramp did not turn");
         // Edge output follows count below duty
         edge_level_a: assert property (@(posedge sys_clk) disable iff (reset)
            (phase_q[gi] != fgpwm_pkg::PH_IDLE && edge_q[gi])
               |=> pwm_q[gi * CN] == ($past(cnt_q[gi]) < $past(duty_q[gi][0])))
            else $error("edge level wrong");
         // Paired outputs are complements while running
         pair_compl_a: assert property (@(posedge sys_clk) disable iff (reset)
            (phase_q[gi] != fgpwm_pkg::PH_IDLE && paired_q[gi])
               |=> (pwm_q[gi * CN + 1] != pwm_q[gi * CN]
                  && pwm_q[gi * CN + 3] != pwm_q[gi * CN + 2]))
            else $error("pair not complementary");
         // Non-paired odd output uses its own duty
         indep_out_a: assert property (@(posedge sys_clk) disable iff (reset)
            (phase_q[gi] != fgpwm_pkg::PH_IDLE && !paired_q[gi] && edge_q[gi])
               |=> pwm_q[gi * CN + 1] == ($past(cnt_q[gi]) < $past(duty_q[gi][1])))
            else $error("independent output wrong");
         // Duties hold between update points
         duty_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
            (!start_d[gi] && !(mid_d[gi] && dbl_q[gi]))
               |=> $stable(duty_q[gi][0]) && $stable(duty_q[gi][3]))
            else $error("duty changed off update point");
         // Double update loads duties at the midpoint
         mid_load_a: assert property (@(posedge sys_clk) disable iff (reset)
            (mid_d[gi] && dbl_q[gi])
               |=> duty_q[gi][2] == $past(duty_of(duty_in, gi, 2)))
            else $error("midpoint load missed");
         // Single update ignores the midpoint
         single_mid_a: assert property (@(posedge sys_clk) disable iff (reset)
            (mid_d[gi] && !dbl_q[gi]) |=> $stable(duty_q[gi][1]))
            else $error("single update loaded at midpoint");
         // Period changes only at a period start, from the input
         per_load_a: assert property (@(posedge sys_clk) disable iff (reset)
            start_d[gi] |=> per_q[gi] == $past(period_in[gi * W +: W]))
            else $error("period load wrong");
         // Between starts the working period holds
         per_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
            !start_d[gi] |=> $stable(per_q[gi]))
            else $error("period changed off start");
      end
   endgenerate

endmodule // fgpwm_top

// file: tb/fgpwm_stage_model.sv
`timescale 1ns/1ps

// Power stage stand-in: measures the on-time of every leg over one whole period
module fgpwm_stage_model (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [15:0] pwm_out,
   input wire logic [3:0] period_start,
   input wire logic [3:0] arm,
   output logic [3:0] rep_valid,
   output logic [7:0] rep_high [16],
   output logic [7:0] rep_len [4]
);
   logic [1:0] st_q [4]; // Per group: 0 idle, 1 armed, 2 measuring

   // The window opens at one period start and closes at the next. It therefore spans
   // exactly one period, whatever the phase lag between outputs and pulses.
   always_ff @(posedge sys_clk)
   begin
      for (int g = 0; g < 4; g++)
      begin
         rep_valid[g] <= 1'b0;
         if (reset)
            st_q[g] <= 2'h0;
         else if (arm[g])
            st_q[g] <= 2'h1;
         else if (period_start[g] && st_q[g] == 2'h1)
         begin
            // First start: open the window with this cycle
            st_q[g] <= 2'h2;
            rep_len[g] <= 8'h01;
            for (int c = 0; c < 4; c++)
               rep_high[4*g+c] <= {7'h00, pwm_out[4*g+c]};
         end
         else if (period_start[g] && st_q[g] == 2'h2)
         begin
            // Second start: the counts freeze and are reported
            st_q[g] <= 2'h0;
            rep_valid[g] <= 1'b1;
         end
         else if (st_q[g] == 2'h2)
         begin
            rep_len[g] <= rep_len[g] + 8'h01;
            for (int c = 0; c < 4; c++)
               rep_high[4*g+c] <= rep_high[4*g+c] + {7'h00, pwm_out[4*g+c]};
         end
      end
   end
endmodule // fgpwm_stage_model

// file: tb/tb_top.sv
`timescale 1ns/1ps

// Self-checking bench: random settings on all groups, plus an update-point case
module tb_top;
   logic sys_clk, reset;
   logic [3:0] grp_enable, grp_edge_mode, grp_dbl_update, grp_paired, arm;
   logic [63:0] period_in;
   logic [255:0] duty_in;
   logic [15:0] pwm_out;
   logic [3:0] period_start, mid_point, rep_valid;
   logic [7:0] rep_high [16];
   logic [7:0] rep_len [4];
   logic [39:0] exp_q [4][$]; // Per group: length then four on-times
   logic [39:0] e_m; // Note taken off the queue
   logic [31:0] rng; // Random state
   int num_errors, tests_run;

   fgpwm_top uut (.sys_clk(sys_clk), .reset(reset), .grp_enable(grp_enable),
      .grp_edge_mode(grp_edge_mode), .grp_dbl_update(grp_dbl_update),
      .grp_paired(grp_paired), .period_in(period_in), .duty_in(duty_in),
      .pwm_out(pwm_out), .period_start(period_start), .mid_point(mid_point));

   fgpwm_stage_model stage (.sys_clk(sys_clk), .reset(reset), .pwm_out(pwm_out),
      .period_start(period_start), .arm(arm), .rep_valid(rep_valid),
      .rep_high(rep_high), .rep_len(rep_len));

   // Clock at 100 MHz
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   // On-time of one leg; centre mode visits every count twice per period
   function automatic logic [7:0] hi_of(input logic em, input logic [7:0] p, input logic [7:0] d);
      if (em)
         return (d >= p) ? p : d;
      return (d >= p) ? 8'(p * 2) : 8'(d * 2);
   endfunction

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic arm_grp(input logic [3:0] m);
      @(posedge sys_clk);
      arm <= m;
      @(posedge sys_clk);
      arm <= 4'h0;
   endtask

   // Bounded wait until every note has been matched by a report
   task automatic drain();
      int n;
      n = 0;
      while (exp_q[0].size() + exp_q[1].size() + exp_q[2].size() + exp_q[3].size() > 0)
      begin
         @(posedge sys_clk);
         n++;
         if (n > 300)
         begin
            num_errors++;
            report_and_stop();
         end
      end
   endtask

   // Fresh random settings on all four groups, then one measured period each
   task automatic rand_round();
      logic [31:0] r;
      logic [7:0] p, len;
      logic [7:0] h [4];
      @(posedge sys_clk);
      for (int g = 0; g < 4; g++)
      begin
         r = rnd();
         p = 8'h02 + 8'(r[6:4]);
         len = r[0] ? p : 8'(p * 2);
         grp_edge_mode[g] <= r[0];
         grp_paired[g] <= r[1];
         grp_dbl_update[g] <= r[2];
         period_in[16*g+:16] <= {8'h00, p};
         for (int c = 0; c < 4; c++)
         begin
            duty_in[(4*g+c)*16+:16] <= {12'h000, r[8+4*c+:4]};
            h[c] = hi_of(r[0], p, {4'h0, r[8+4*c+:4]});
         end
         if (r[1])
         begin
            h[1] = len - h[0];
            h[3] = len - h[2];
         end
         exp_q[g].push_back({len, h[3], h[2], h[1], h[0]});
      end
      repeat (40) @(posedge sys_clk);
      arm_grp(4'hf);
      drain();
   endtask

   // New duty and period written just after a start: only the midpoint may take the duty
   task automatic dbl_case(input logic db);
      int n;
      @(posedge sys_clk);
      grp_edge_mode[0] <= 1'b0;
      grp_paired[0] <= 1'b0;
      grp_dbl_update[0] <= db;
      period_in[15:0] <= 16'h0008;
      duty_in[63:0] <= {4{16'h0002}};
      repeat (40) @(posedge sys_clk);
      arm_grp(4'h1);
      exp_q[0].push_back({8'h10, {4{db ? 8'h07 : 8'h04}}});
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (period_start[0] !== 1'b1 && n < 100);
      if (period_start[0] !== 1'b1)
      begin
         num_errors++;
         report_and_stop();
      end
      duty_in[63:0] <= {4{16'h0005}};
      period_in[15:0] <= 16'h000c;
      // The ramp turns P cycles after the start pulse: one midpoint pulse there
      repeat (7) @(posedge sys_clk);
      check("mid_early", 8'h00, {7'h00, mid_point[0]});
      @(posedge sys_clk);
      check("mid_point", 8'h01, {7'h00, mid_point[0]});
      drain();
   endtask

   // Monitor: each report is matched against the oldest note of its group
   always @(posedge sys_clk)
   begin
      for (int g = 0; g < 4; g++)
      begin
         if (rep_valid[g] === 1'b1)
         begin
            e_m = (exp_q[g].size() > 0) ? exp_q[g].pop_front() : 40'h0;
            check("period", e_m[39:32], rep_len[g]);
            for (int c = 0; c < 4; c++)
               check("on_time", e_m[8*c+:8], rep_high[4*g+c]);
         end
      end
   end

   // Main sequence
   initial
   begin
      reset = 1'b1;
      grp_enable = 4'h0;
      grp_edge_mode = 4'h0;
      grp_dbl_update = 4'h0;
      grp_paired = 4'h0;
      period_in = 64'h0;
      duty_in = 256'h0;
      arm = 4'h0;
      rng = 32'd77796;
      num_errors = 0;
      tests_run = 0;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      grp_enable <= 4'hf;
      repeat (10) rand_round();
      dbl_case(1'b1);
      dbl_case(1'b0);
      grp_enable <= 4'h0;
      repeat (3) @(posedge sys_clk);
      check("pwm_lo", 8'h00, pwm_out[7:0]);
      check("pwm_hi", 8'h00, pwm_out[15:8]);
      report_and_stop();
   end
endmodule // tb_top
